// [rtl/odt_pkg.sv]
// constants and types for the on-die termination controller
package odt_pkg;
    // termination state, lowest code is hi-z
    typedef enum logic [1:0] {TERM_HIZ, TERM_PARK, TERM_NOM, TERM_WR} term_t;
    // decoded command presented on the command pins at a link clock edge
    localparam logic [2:0] CMD_NOP = 3'h0;
    localparam logic [2:0] CMD_WR  = 3'h1;
    localparam logic [2:0] CMD_RD  = 3'h2;
    localparam logic [2:0] CMD_ZQ  = 3'h3;
    localparam logic [2:0] CMD_SRE = 3'h4;
    localparam logic [2:0] CMD_SRX = 3'h5;
    // latency offsets
    localparam logic [6:0] ODT_OFS_1T   = 7'h2;
    localparam logic [6:0] ODT_OFS_2T   = 7'h3;
    localparam logic [3:0] RD_X_1T      = 4'h2;
    localparam logic [3:0] RD_X_2T      = 4'h3;
    localparam logic [3:0] RD_Y_CRC     = 4'h1;
    localparam logic [3:0] RD_Y_NOCRC   = 4'h0;
    localparam logic [3:0] RD_HALF_BL8  = 4'h4;
    localparam logic [3:0] RD_HALF_BC4  = 4'h2;
    // write window length (cwn - cnw) by {burst_bc4, preamble_2t, crc_on}
    localparam logic [3:0] WR_LEN_BC4_1T  = 4'h4;
    localparam logic [3:0] WR_LEN_BC4_1TC = 4'h7;
    localparam logic [3:0] WR_LEN_BC4_2T  = 4'h5;
    localparam logic [3:0] WR_LEN_BC4_2TC = 4'h8;
    localparam logic [3:0] WR_LEN_BL8_1T  = 4'h6;
    localparam logic [3:0] WR_LEN_BL8_1TC = 4'h7;
    localparam logic [3:0] WR_LEN_BL8_2T  = 4'h7;
    localparam logic [3:0] WR_LEN_BL8_2TC = 4'h8;
    // effective ohms for nominal and park field codes 1..7
    localparam logic [7:0] OHM_NONE = 8'h00;
    localparam logic [7:0] OHM_60   = 8'h3c;
    localparam logic [7:0] OHM_120  = 8'h78;
    localparam logic [7:0] OHM_40   = 8'h28;
    localparam logic [7:0] OHM_240  = 8'hf0;
    localparam logic [7:0] OHM_48   = 8'h30;
    localparam logic [7:0] OHM_80   = 8'h50;
    localparam logic [7:0] OHM_34   = 8'h22;
    // calibration window in link clock cycles
    localparam int ZQ_TICKS_DEF = 256;
endpackage

// [rtl/odt_ctrl.sv]
// on-die termination state controller of a memory device
`timescale 1ns/10ps
// Overview of operation
// - controller holds odt low in calibration; device keeps parked termination.
// - termination covers data, strobe, mask; x8 strobe pair only if enabled.
// - self-refresh forces hi-z regardless of mode fields.
// - odt pin ignored when nominal field is zero or in self-refresh.
// - odt mode enabled when nominal, write or park field nonzero.
// - written rank applies write termination for the write window, ignoring odt.
// - odt high with nominal enabled selects nominal termination.
// - park enabled and odt low selects park termination.
// - read turns termination off from RL-X for BL/2+X+Y cycles.
// - X is 2 with 1tCK preamble, 3 with 2tCK.
// - Y is 0 without write CRC, 1 with it.
// - priority: read disable, write, nominal, park.
// - idle: odt high gives nominal, else park if enabled, else hi-z.
// - nominal disabled powers down the odt receiver.
// - synchronous odt mode whenever the delay-locked loop is on.
// - nominal turns on/off a set latency after odt sampled high/low.
// - 1tCK preamble latency is WL-2 where WL=CWL+AL+PL.
// - 2tCK preamble latency is WL-3.
// - effective values 240,120,80,60,48,40,34 ohms from mode fields.
// - dynamic write termination enabled if either write field bit set.
// - write termination starts WL-2 or WL-3 after the write command.
// - with the loop off, asynchronous mode: odt not delayed.
module odt_ctrl #(
    parameter int MAXL     = 64,
    parameter int ZQ_TICKS = odt_pkg::ZQ_TICKS_DEF
) (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              link_ck,
    input  wire logic              odt_pin,
    input  wire logic [2:0]        cmd_pin,
    input  wire logic [2:0]        rtt_nom_sel,
    input  wire logic [1:0]        rtt_wr_sel,
    input  wire logic [2:0]        rtt_park_sel,
    input  wire logic              dll_on,
    input  wire logic              tdqs_on,
    input  wire logic              x8_part,
    input  wire logic              preamble_2t,
    input  wire logic              crc_on,
    input  wire logic              burst_bc4,
    input  wire logic [4:0]        cas_lat,
    input  wire logic [4:0]        cas_wr_lat,
    input  wire logic [4:0]        add_lat,
    input  wire logic [2:0]        par_lat,
    output logic [1:0]             term_state,
    output logic [7:0]             term_ohms,
    output logic                   dq_term_on,
    output logic                   tdqs_term_on,
    output logic                   odt_rx_on,
    output logic                   self_refresh,
    output logic                   zq_busy
);
    localparam int LW = $clog2(MAXL);
    localparam int ZW = $clog2(ZQ_TICKS + 1);

    if (MAXL < 48 || MAXL > 128) begin : g_bad_maxl
        $error("MAXL must lie in 48..128");
    end
    if (ZQ_TICKS < 1) begin : g_bad_zq
        $error("ZQ_TICKS must be at least 1");
    end

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic                ck_s1;
        logic                ck_s2;
        logic                ck_s3;
        logic                odt_s1;
        logic                odt_s2;
        logic [2:0]          cmd_s1;
        logic [2:0]          cmd_s2;
        logic [MAXL-1:0]     odt_hist;
        logic [MAXL-1:0]     rd_hist;
        logic [MAXL-1:0]     wr_hist;
        logic [3:0]          rd_cnt;
        logic [3:0]          wr_cnt;
        logic [ZW-1:0]       zq_cnt;
        logic                sr;
        odt_pkg::term_t      term;
        logic [7:0]          ohms;
        logic                dq_en;
        logic                tdqs_en;
        logic                rx_en;
        logic                zq_on;
    } st_t;

    st_t q, d;

    function automatic logic [7:0] ohm_of(input logic [2:0] code);
        unique case (code)
            3'h1: ohm_of = odt_pkg::OHM_60;
            3'h2: ohm_of = odt_pkg::OHM_120;
            3'h3: ohm_of = odt_pkg::OHM_40;
            3'h4: ohm_of = odt_pkg::OHM_240;
            3'h5: ohm_of = odt_pkg::OHM_48;
            3'h6: ohm_of = odt_pkg::OHM_80;
            3'h7: ohm_of = odt_pkg::OHM_34;
            3'h0: ohm_of = odt_pkg::OHM_NONE;
        endcase
    endfunction

    function automatic logic [7:0] wr_ohm_of(input logic [1:0] code);
        unique case (code)
            2'h1: wr_ohm_of = odt_pkg::OHM_120;
            2'h2: wr_ohm_of = odt_pkg::OHM_240;
            2'h3: wr_ohm_of = odt_pkg::OHM_80;
            2'h0: wr_ohm_of = odt_pkg::OHM_NONE;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // latency arithmetic
    // ---------------------------------------------------------------
    logic       nom_en;
    logic       park_en;
    logic       dyn_en;
    logic       odt_mode;
    logic       tick;
    logic [6:0] wl;
    logic [6:0] rl;
    logic [6:0] dodtl;
    logic [6:0] rd_lat;
    logic [3:0] rd_x;
    logic [3:0] rd_len;
    logic [3:0] wr_len;

    always_comb begin
        nom_en   = rtt_nom_sel != 3'h0;
        park_en  = rtt_park_sel != 3'h0;
        dyn_en   = rtt_wr_sel[0] | rtt_wr_sel[1];
        odt_mode = nom_en | dyn_en | park_en;
        tick     = q.ck_s2 & ~q.ck_s3;
        wl       = 7'(cas_wr_lat) + 7'(add_lat) + 7'(par_lat);
        rl       = 7'(cas_lat) + 7'(add_lat) + 7'(par_lat);
        dodtl    = wl - (preamble_2t ? odt_pkg::ODT_OFS_2T
                                     : odt_pkg::ODT_OFS_1T);
        rd_x     = preamble_2t ? odt_pkg::RD_X_2T : odt_pkg::RD_X_1T;
        rd_lat   = rl - 7'(rd_x);
        rd_len   = (burst_bc4 ? odt_pkg::RD_HALF_BC4 : odt_pkg::RD_HALF_BL8)
                   + rd_x
                   + (crc_on ? odt_pkg::RD_Y_CRC : odt_pkg::RD_Y_NOCRC);
        unique case ({burst_bc4, preamble_2t, crc_on})
            3'b100:  wr_len = odt_pkg::WR_LEN_BC4_1T;
            3'b101:  wr_len = odt_pkg::WR_LEN_BC4_1TC;
            3'b110:  wr_len = odt_pkg::WR_LEN_BC4_2T;
            3'b111:  wr_len = odt_pkg::WR_LEN_BC4_2TC;
            3'b000:  wr_len = odt_pkg::WR_LEN_BL8_1T;
            3'b001:  wr_len = odt_pkg::WR_LEN_BL8_1TC;
            3'b010:  wr_len = odt_pkg::WR_LEN_BL8_2T;
            3'b011:  wr_len = odt_pkg::WR_LEN_BL8_2TC;
        endcase
    end

    // picks the sample taken lat link edges ago; zero means the current one
    function automatic logic delayed(input logic [MAXL-1:0] hist, input logic now,
                                     input logic [6:0] lat);
        logic [LW-1:0] idx;
        idx = LW'(lat - 7'h1);
        delayed = (lat == 7'h0) ? now : hist[idx];
    endfunction

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    logic odt_now;
    logic odt_eff;
    logic rd_hit;
    logic wr_hit;
    logic rd_act;
    logic wr_act;
    logic zq_act;

    always_comb begin
        d        = q;
        d.ck_s1  = link_ck;
        d.ck_s2  = q.ck_s1;
        d.ck_s3  = q.ck_s2;
        d.odt_s1 = odt_pin;
        d.odt_s2 = q.odt_s1;
        d.cmd_s1 = cmd_pin;
        d.cmd_s2 = q.cmd_s1;
        d.rx_en  = nom_en & ~q.sr;
        odt_now  = q.odt_s2 & nom_en & ~q.sr;
        odt_eff  = dll_on ? delayed(q.odt_hist, odt_now, dodtl)
                          : odt_now;
        rd_hit   = delayed(q.rd_hist, q.cmd_s2 == odt_pkg::CMD_RD, rd_lat);
        wr_hit   = delayed(q.wr_hist, q.cmd_s2 == odt_pkg::CMD_WR, dodtl);
        rd_act   = rd_hit | (q.rd_cnt != 4'h0);
        wr_act   = (wr_hit | (q.wr_cnt != 4'h0)) & dyn_en;
        // the calibration edge itself already blocks nominal
        zq_act   = (q.zq_cnt != ZW'(0)) | (q.cmd_s2 == odt_pkg::CMD_ZQ);
        if (tick) begin
            d.odt_hist = {q.odt_hist[MAXL-2:0], odt_now};
            d.rd_hist  = {q.rd_hist[MAXL-2:0], q.cmd_s2 == odt_pkg::CMD_RD};
            d.wr_hist  = {q.wr_hist[MAXL-2:0], q.cmd_s2 == odt_pkg::CMD_WR};
            d.rd_cnt   = rd_hit ? rd_len - 4'h1
                                : (q.rd_cnt != 4'h0 ? q.rd_cnt - 4'h1 : 4'h0);
            d.wr_cnt   = wr_hit ? wr_len - 4'h1
                                : (q.wr_cnt != 4'h0 ? q.wr_cnt - 4'h1 : 4'h0);
            // calibration blocks nominal itself for ZQ_TICKS link edges after the command edge, whatever the odt pin does
            if (q.cmd_s2 == odt_pkg::CMD_ZQ) begin
                d.zq_cnt = ZW'(ZQ_TICKS);
            end else if (zq_act) begin
                d.zq_cnt = q.zq_cnt - ZW'(1);
            end
            if (q.cmd_s2 == odt_pkg::CMD_SRE) begin
                d.sr = 1'b1;
            end else if (q.cmd_s2 == odt_pkg::CMD_SRX) begin
                d.sr = 1'b0;
            end
            // priority resolution at each link edge
            if (d.sr || !odt_mode) begin
                d.term = odt_pkg::TERM_HIZ;
            end else if (rd_act) begin
                d.term = odt_pkg::TERM_HIZ;
            end else if (wr_act) begin
                d.term = odt_pkg::TERM_WR;
            end else if (odt_eff && !zq_act) begin
                d.term = odt_pkg::TERM_NOM;
            end else if (park_en) begin
                d.term = odt_pkg::TERM_PARK;
            end else begin
                d.term = odt_pkg::TERM_HIZ;
            end
            unique case (d.term)
                odt_pkg::TERM_HIZ:  d.ohms = odt_pkg::OHM_NONE;
                odt_pkg::TERM_PARK: d.ohms = ohm_of(rtt_park_sel);
                odt_pkg::TERM_NOM:  d.ohms = ohm_of(rtt_nom_sel);
                odt_pkg::TERM_WR:   d.ohms = wr_ohm_of(rtt_wr_sel);
            endcase
            d.dq_en   = d.term != odt_pkg::TERM_HIZ;
            d.tdqs_en = (d.term != odt_pkg::TERM_HIZ) & x8_part & tdqs_on;
        end
        d.zq_on = d.zq_cnt != ZW'(0);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign term_state   = q.term;
    assign term_ohms    = q.ohms;
    assign dq_term_on   = q.dq_en;
    assign tdqs_term_on = q.tdqs_en;
    assign odt_rx_on    = q.rx_en;
    assign self_refresh = q.sr;
    assign zq_busy      = q.zq_on;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_sr_hiz;
        q.sr |-> q.term == odt_pkg::TERM_HIZ && !q.dq_en;
    endproperty
    a_sr_hiz: assert property (p_sr_hiz) else $error("term on in self-refresh");

    property p_rx_off;
        $past(rtt_nom_sel) == 3'h0 |-> !q.rx_en;
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("odt receiver on");

    property p_rd_off;
        q.rd_cnt != 4'h0 |-> q.term == odt_pkg::TERM_HIZ;
    endproperty
    a_rd_off: assert property (p_rd_off) else $error("term on during read");

    property p_wr_on;
        q.wr_cnt != 4'h0 && q.rd_cnt == 4'h0 && !q.sr && dyn_en
            |-> q.term == odt_pkg::TERM_WR;
    endproperty
    a_wr_on: assert property (p_wr_on) else $error("write term missing");

    property p_park_src;
        q.term == odt_pkg::TERM_PARK && $past(tick) |-> $past(rtt_park_sel) != 3'h0;
    endproperty
    a_park_src: assert property (p_park_src) else $error("park without enable");

    property p_nom_src;
        q.term == odt_pkg::TERM_NOM && $past(tick) |-> $past(rtt_nom_sel) != 3'h0 && !q.sr;
    endproperty
    a_nom_src: assert property (p_nom_src) else $error("nominal without enable");

    property p_tdqs;
        q.tdqs_en |-> q.dq_en && (!$past(tick) || ($past(x8_part) && $past(tdqs_on)));
    endproperty
    a_tdqs: assert property (p_tdqs) else $error("strobe pair term bad");

    property p_zq_park;
        zq_busy && q.rd_cnt == 4'h0 && q.wr_cnt == 4'h0
            |-> q.term != odt_pkg::TERM_NOM;
    endproperty
    a_zq_park: assert property (p_zq_park) else $error("nominal during calibration");

    property p_hold;
        !tick |=> $stable(q.term);
    endproperty
    a_hold: assert property (p_hold) else $error("term changed off edge");

    c_nom:  cover property (q.term == odt_pkg::TERM_NOM);
    c_wr:   cover property (q.term == odt_pkg::TERM_WR);
    c_rd:   cover property (q.rd_cnt != 4'h0);
    c_sr:   cover property (q.sr ##1 !q.sr);
endmodule

// [verif/odt_host_model.sv]
// controller-side model: free-running link clock, odt pin and command pins
`timescale 1ns/10ps
module odt_host_model (
    input  wire logic       clock,
    output logic            link_ck,
    output logic            odt_pin,
    output logic [2:0]      cmd_pin
);
    // ----------------------------------------
    // link clock, phase unrelated to clock
    // ----------------------------------------
    initial begin
        link_ck = 1'b0;
        odt_pin = 1'b0;
        cmd_pin = odt_pkg::CMD_NOP;
        #37;
        forever begin
            #80 link_ck = ~link_ck;
        end
    end

    // ----------------------------------------
    // one command per link edge, held until sampled
    // ----------------------------------------
    task automatic step(input logic [2:0] cmd, input logic odt);
        @(posedge clock);
        cmd_pin <= cmd;
        odt_pin <= odt;
        @(posedge link_ck);
    endtask
endmodule

// [verif/test_odt_ctrl.sv]
// self-checking bench for the termination state controller
`timescale 1ns/10ps
module test_odt_ctrl;
    logic             clock;
    logic             rst;
    logic             link_ck;
    logic             odt_pin;
    logic [2:0]       cmd_pin;
    logic [2:0]       rtt_nom_sel;
    logic [1:0]       rtt_wr_sel;
    logic [2:0]       rtt_park_sel;
    logic             dll_on;
    logic             tdqs_on;
    logic             x8_part;
    logic             preamble_2t;
    logic             crc_on;
    logic             burst_bc4;
    logic [4:0]       cas_lat;
    logic [4:0]       cas_wr_lat;
    logic [4:0]       add_lat;
    logic [2:0]       par_lat;
    logic [1:0]       term_state;
    logic [7:0]       term_ohms;
    logic             dq_term_on;
    logic             tdqs_term_on;
    logic             odt_rx_on;
    logic             self_refresh;
    logic             zq_busy;
    int               errors;
    int               comparisons;

    odt_ctrl #(.ZQ_TICKS(4)) u_odt_ctrl (.clock(clock), .rst(rst), .link_ck(link_ck),
        .odt_pin(odt_pin), .cmd_pin(cmd_pin), .rtt_nom_sel(rtt_nom_sel),
        .rtt_wr_sel(rtt_wr_sel), .rtt_park_sel(rtt_park_sel), .dll_on(dll_on),
        .tdqs_on(tdqs_on), .x8_part(x8_part), .preamble_2t(preamble_2t), .crc_on(crc_on),
        .burst_bc4(burst_bc4), .cas_lat(cas_lat), .cas_wr_lat(cas_wr_lat), .add_lat(add_lat),
        .par_lat(par_lat), .term_state(term_state), .term_ohms(term_ohms),
        .dq_term_on(dq_term_on), .tdqs_term_on(tdqs_term_on), .odt_rx_on(odt_rx_on),
        .self_refresh(self_refresh), .zq_busy(zq_busy));

    odt_host_model u_odt_host_model (.clock(clock), .link_ck(link_ck), .odt_pin(odt_pin),
        .cmd_pin(cmd_pin));

    always #10 clock = ~clock;

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic compare(input logic [7:0] got, input logic [7:0] want);
        comparisons++;
        if (got !== want) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, want);
        end
    endtask

    task automatic test_done();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic idle(input int n, input logic odt);
        repeat (n) u_odt_host_model.step(odt_pkg::CMD_NOP, odt);
        repeat (6) @(posedge clock);
    endtask

    // command at link edge 0, state checked after every edge up to n
    task automatic play(input logic [2:0] cmd, input logic odt, input int n, input int first,
                        input int last, input odt_pkg::term_t win, input odt_pkg::term_t base);
        logic [7:0] want;
        for (int k = 0; k <= n; k++) begin
            u_odt_host_model.step((k == 0) ? cmd : odt_pkg::CMD_NOP, odt);
            repeat (6) @(posedge clock);
            want = (k >= first && k <= last) ? {6'h00, win} : {6'h00, base};
            compare({6'h00, term_state}, want);
        end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_idle_table();
        logic [7:0]     ohm [8];
        odt_pkg::term_t want;
        ohm = '{odt_pkg::OHM_NONE, odt_pkg::OHM_60, odt_pkg::OHM_120, odt_pkg::OHM_40,
                odt_pkg::OHM_240, odt_pkg::OHM_48, odt_pkg::OHM_80, odt_pkg::OHM_34};
        for (int c = 0; c < 8; c++) begin
            for (int m = 0; m < 3; m++) begin
                @(posedge clock);
                rtt_park_sel <= (m == 0) ? 3'(c) : 3'h0;
                rtt_nom_sel  <= (m == 0) ? 3'h0 : 3'(c);
                want = (c == 0 || m == 2) ? odt_pkg::TERM_HIZ :
                       (m == 0) ? odt_pkg::TERM_PARK : odt_pkg::TERM_NOM;
                idle(2, m != 2);
                compare({6'h00, term_state}, {6'h00, want});
                compare(term_ohms, (m == 2) ? 8'h00 : ohm[c]);
                compare({7'h00, odt_rx_on}, {7'h00, m != 0 && c != 0});
            end
        end
        // loop off: odt acts at the very edge it is sampled
        @(posedge clock);
        rtt_nom_sel  <= 3'h1;
        rtt_park_sel <= 3'h2;
        idle(2, 1'b0);
        play(odt_pkg::CMD_NOP, 1'b1, 1, 0, 1, odt_pkg::TERM_NOM,
             odt_pkg::TERM_PARK);
    endtask

    task automatic t_sync_latency();
        int lat;
        for (int p = 0; p < 2; p++) begin
            @(posedge clock);
            dll_on       <= 1'b1;
            rtt_nom_sel  <= 3'h1;
            rtt_park_sel <= 3'h2;
            preamble_2t  <= p[0];
            cas_wr_lat   <= (p == 0) ? 5'h09 : 5'h0c;
            add_lat      <= (p == 0) ? 5'h00 : 5'h02;
            par_lat      <= (p == 0) ? 3'h0 : 3'h1;
            lat = (p == 0) ? 7 : 12;
            idle(16, 1'b0);
            play(odt_pkg::CMD_NOP, 1'b1, lat + 2, lat, lat + 2, odt_pkg::TERM_NOM,
                 odt_pkg::TERM_PARK);
            play(odt_pkg::CMD_NOP, 1'b0, lat + 2, 0, lat - 1, odt_pkg::TERM_NOM,
                 odt_pkg::TERM_PARK);
        end
    endtask

    task automatic t_write();
        @(posedge clock);
        preamble_2t <= 1'b0;
        cas_wr_lat  <= 5'h09;
        add_lat     <= 5'h00;
        par_lat     <= 3'h0;
        crc_on      <= 1'b1;
        burst_bc4   <= 1'b1;
        idle(16, 1'b0);
        play(odt_pkg::CMD_WR, 1'b0, 14, 7, 13, odt_pkg::TERM_WR,
             odt_pkg::TERM_PARK);
        @(posedge clock);
        crc_on    <= 1'b0;
        burst_bc4 <= 1'b0;
        play(odt_pkg::CMD_NOP, 1'b1, 8, 7, 8, odt_pkg::TERM_NOM, odt_pkg::TERM_PARK);
        play(odt_pkg::CMD_WR, 1'b1, 14, 7, 12, odt_pkg::TERM_WR,
             odt_pkg::TERM_NOM);
        compare(term_ohms, odt_pkg::OHM_60);
        @(posedge clock);
        rtt_wr_sel <= 2'h0;
        play(odt_pkg::CMD_WR, 1'b1, 14, 15, 15, odt_pkg::TERM_WR, odt_pkg::TERM_NOM);
        @(posedge clock);
        rtt_wr_sel <= 2'h3;
    endtask

    task automatic t_read();
        play(odt_pkg::CMD_RD, 1'b1, 16, 9, 14, odt_pkg::TERM_HIZ,
             odt_pkg::TERM_NOM);
        @(posedge clock);
        preamble_2t <= 1'b1;
        crc_on      <= 1'b1;
        burst_bc4   <= 1'b1;
        cas_wr_lat  <= 5'h0a;
        cas_lat     <= 5'h0c;
        idle(16, 1'b1);
        play(odt_pkg::CMD_RD, 1'b1, 15, 9, 14, odt_pkg::TERM_HIZ,
             odt_pkg::TERM_NOM);
    endtask

    task automatic t_refresh_zq();
        play(odt_pkg::CMD_SRE, 1'b1, 3, 0, 3, odt_pkg::TERM_HIZ, odt_pkg::TERM_NOM);
        compare({7'h00, self_refresh}, 8'h01);
        compare({7'h00, odt_rx_on}, 8'h00);
        compare({7'h00, dq_term_on}, 8'h00);
        u_odt_host_model.step(odt_pkg::CMD_SRX, 1'b0);
        idle(12, 1'b0);
        compare({7'h00, self_refresh}, 8'h00);
        compare({6'h00, term_state}, {6'h00, odt_pkg::TERM_PARK});
        u_odt_host_model.step(odt_pkg::CMD_ZQ, 1'b0);
        idle(1, 1'b0);
        compare({7'h00, zq_busy}, 8'h01);
        compare({6'h00, term_state}, {6'h00, odt_pkg::TERM_PARK});
        idle(6, 1'b0);
        compare({7'h00, zq_busy}, 8'h00);
        compare({7'h00, dq_term_on}, 8'h01);
        compare({7'h00, tdqs_term_on}, 8'h01);
        @(posedge clock);
        tdqs_on <= 1'b0;
        idle(2, 1'b0);
        compare({7'h00, tdqs_term_on}, 8'h00);
        // strobe pair only exists on the x8 organisation
        @(posedge clock);
        tdqs_on <= 1'b1;
        x8_part <= 1'b0;
        idle(2, 1'b0);
        compare({7'h00, tdqs_term_on}, 8'h00);
        compare({7'h00, dq_term_on}, 8'h01);
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        clock        = 1'b0;
        rst          = 1'b1;
        rtt_nom_sel  = 3'h1;
        rtt_wr_sel   = 2'h3;
        rtt_park_sel = 3'h2;
        dll_on       = 1'b0;
        tdqs_on      = 1'b1;
        x8_part      = 1'b1;
        cas_lat      = 5'h0b;
        preamble_2t  = 1'b0;
        crc_on       = 1'b0;
        burst_bc4    = 1'b0;
        cas_wr_lat   = 5'h09;
        add_lat      = 5'h00;
        par_lat      = 3'h0;
        errors       = 0;
        comparisons  = 0;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        t_idle_table();
        t_sync_latency();
        t_write();
        t_read();
        @(posedge clock);
        preamble_2t <= 1'b0;
        crc_on      <= 1'b0;
        burst_bc4   <= 1'b0;
        cas_wr_lat  <= 5'h09;
        idle(12, 1'b1);
        t_refresh_zq();
        test_done();
    end

    initial begin
        #500000;
        errors++;
        $display("BAD %0t watchdog expired", $time);
        test_done();
    end
endmodule
